// file: cipr_pkg.sv
// Package of constants for the CIP I/O object responder
`default_nettype none
package cipr_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int FLASH_MS = 500;
  localparam int FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
  localparam int NUM_IN = 8;
  localparam int NUM_OUT = 4;
  localparam int DW = 16;
  localparam int AW = 4;
  // Register offsets
  localparam logic [3:0] REG_RPI = 4'h0;
  localparam logic [3:0] REG_MULT = 4'h1;
  localparam logic [3:0] REG_IRQ_STS = 4'h2;
  localparam logic [3:0] REG_IRQ_MASK = 4'h3;
  localparam logic [3:0] REG_ID_STATUS = 4'h4;
  localparam logic [3:0] REG_ID_STATE = 4'h5;
  localparam logic [3:0] REG_SUBST = 4'h6;
  localparam logic [15:0] RPI_RST = 16'h2710;
  localparam logic [2:0] MULT_RST = 3'h0;
  localparam logic [3:0] MULT_BASE = 4'h2;
  // Interrupt bits
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_SHORT = 1;
  localparam int IRQ_BADREQ = 2;
  localparam int IRQ_W = 3;
  // Services
  localparam logic [7:0] SVC_GET_ALL = 8'h01;
  localparam logic [7:0] SVC_SET_ALL = 8'h02;
  localparam logic [7:0] SVC_RESET = 8'h05;
  localparam logic [7:0] SVC_DELETE = 8'h09;
  localparam logic [7:0] SVC_GET_SGL = 8'h0E;
  localparam logic [7:0] SVC_SET_SGL = 8'h10;
  // Classes
  localparam logic [7:0] CLS_IDENT = 8'h01;
  localparam logic [7:0] CLS_ASSY = 8'h04;
  localparam logic [7:0] CLS_CONN = 8'h06;
  localparam logic [7:0] CLS_DIP = 8'h08;
  localparam logic [7:0] CLS_DOP = 8'h09;
  localparam logic [7:0] CLS_RING = 8'h47;
  localparam logic [7:0] CLS_QOS = 8'h48;
  localparam logic [7:0] CLS_TCPIP = 8'hF5;
  localparam logic [7:0] CLS_LINK = 8'hF6;
  // Identity values
  localparam logic [15:0] ID_VERSION = 16'h0001;
  localparam logic [15:0] ID_MAX_INST = 16'h0001;
  localparam logic [15:0] ID_MAX_CLS_ATTR = 16'h0007;
  localparam logic [15:0] ID_MAX_INST_ATTR = 16'h0009;
  localparam logic [7:0] ATTR_VERSION = 8'h01;
  localparam logic [7:0] ATTR_MAX_INST = 8'h02;
  localparam logic [7:0] ATTR_MAX_CLS = 8'h06;
  localparam logic [7:0] ATTR_MAX_IATTR = 8'h07;
  localparam logic [7:0] ATTR_VENDOR = 8'h01;
  localparam logic [7:0] ATTR_PRODUCT = 8'h03;
  localparam logic [7:0] ATTR_STATUS = 8'h05;
  localparam logic [7:0] ATTR_STATE = 8'h08;
  localparam logic [7:0] ATTR_DATA = 8'h03;
  localparam logic [7:0] INST_CLASS = 8'h00;
  localparam logic [7:0] INST_SUBST = 8'd102;
  // State byte encodings
  localparam logic [7:0] ST_NONEXIST = 8'h00;
  localparam logic [7:0] ST_SELFTEST = 8'h01;
  localparam logic [7:0] ST_STANDBY = 8'h02;
  localparam logic [7:0] ST_OPER = 8'h03;
  localparam logic [7:0] ST_MAJ_REC = 8'h04;
  localparam logic [7:0] ST_MAJ_UNREC = 8'h05;
  localparam logic [7:0] ST_GETALL = 8'hFF;
  // Status word bits
  localparam int SW_OWNED = 0;
  localparam int SW_CONFIGURED = 2;
  localparam int SW_EXT_TIMEOUT = 4;
  localparam int SW_MINOR_REC = 8;
  localparam int SW_MAJOR_REC = 10;
endpackage
`default_nettype wire

// file: cipr_req_if.sv
// Interface between the top and the request decoder
`default_nettype none
interface cipr_req_if;
  logic req_valid;
  logic [7:0] service;
  logic [7:0] class_code;
  logic [7:0] instance_id;
  logic [7:0] attr;
  logic [15:0] wdata;
  logic [15:0] status_word;
  logic [7:0] state_byte;
  logic rsp_valid;
  logic rsp_err;
  logic [15:0] rsp_data;
  logic sub_we;
  logic [3:0] sub_data;
  logic rst_svc;
  modport decoder (input req_valid, service, class_code, instance_id, attr, wdata, status_word, state_byte,
                   output rsp_valid, rsp_err, rsp_data, sub_we, sub_data, rst_svc);
  modport top (output req_valid, service, class_code, instance_id, attr, wdata, status_word, state_byte,
               input rsp_valid, rsp_err, rsp_data, sub_we, sub_data, rst_svc);
endinterface
`default_nettype wire

// file: cipr_wdog.sv
// Connection supervision watchdog
`default_nettype none
module cipr_wdog (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic kick_i,
  input wire logic [31:0] limit_i,
  output logic owned_o,
  output logic timeout_o
);
  logic [31:0] cnt_q, cnt_d;
  logic armed_q, armed_d;
  logic to_q, to_d;

  always_comb begin
    cnt_d = cnt_q;
    armed_d = armed_q;
    to_d = 1'b0;
    if (kick_i) begin
      cnt_d = '0;
      armed_d = 1'b1;
    end else if (armed_q) begin
      if (cnt_q >= limit_i - 32'h0000_0001) begin
        to_d = 1'b1;
        armed_d = 1'b0;
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
      armed_q <= 1'b0;
      to_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      armed_q <= armed_d;
      to_q <= to_d;
    end
  end

  assign owned_o = armed_q;
  assign timeout_o = to_q;

  property p_to_pulse;
    @(posedge sys_clk_i) disable iff (!resetn_i) to_q |=> !to_q;
  endproperty
  a_to_pulse: assert property (p_to_pulse) else $error("timeout not a single pulse");
  property p_kick_clears;
    @(posedge sys_clk_i) disable iff (!resetn_i) kick_i |=> armed_q && cnt_q == 32'h0000_0000 && !to_q;
  endproperty
  a_kick_clears: assert property (p_kick_clears) else $error("frame did not restart supervision");
endmodule
`default_nettype wire

// file: cipr_decode.sv
// Explicit request decoder and identity attribute server
`default_nettype none
module cipr_decode #(
  parameter logic [15:0] VENDOR_CODE = 16'h00A5, // Arbitrary value
  parameter logic [15:0] PRODUCT_CODE = 16'h005A // Arbitrary value
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  cipr_req_if.decoder bus
);
  function automatic logic svc_ok(input logic [7:0] s);
    unique case (s)
      cipr_pkg::SVC_GET_ALL, cipr_pkg::SVC_SET_ALL, cipr_pkg::SVC_RESET,
      cipr_pkg::SVC_DELETE, cipr_pkg::SVC_GET_SGL, cipr_pkg::SVC_SET_SGL: svc_ok = 1'b1;
      default: svc_ok = 1'b0;
    endcase
  endfunction

  function automatic logic cls_ok(input logic [7:0] c);
    unique case (c)
      cipr_pkg::CLS_IDENT, cipr_pkg::CLS_ASSY, cipr_pkg::CLS_CONN, cipr_pkg::CLS_DIP, cipr_pkg::CLS_DOP,
      cipr_pkg::CLS_RING, cipr_pkg::CLS_QOS, cipr_pkg::CLS_TCPIP, cipr_pkg::CLS_LINK: cls_ok = 1'b1;
      default: cls_ok = 1'b0;
    endcase
  endfunction

  logic rv_q, rv_d, err_q, err_d, swe_q, swe_d, rst_q, rst_d;
  logic [15:0] dat_q, dat_d;
  logic [3:0] sd_q, sd_d;
  logic is_id, is_sub;

  always_comb begin
    rv_d = bus.req_valid;
    err_d = 1'b0;
    dat_d = '0;
    swe_d = 1'b0;
    sd_d = sd_q;
    rst_d = 1'b0;
    is_id = bus.class_code == cipr_pkg::CLS_IDENT;
    is_sub = bus.class_code == cipr_pkg::CLS_ASSY && bus.instance_id == cipr_pkg::INST_SUBST;
    if (bus.req_valid) begin
      if (!svc_ok(bus.service) || !cls_ok(bus.class_code)) begin
        err_d = 1'b1;
      end else if (is_id && bus.service == cipr_pkg::SVC_GET_SGL && bus.instance_id == cipr_pkg::INST_CLASS) begin
        unique case (bus.attr)
          cipr_pkg::ATTR_VERSION: dat_d = cipr_pkg::ID_VERSION;
          cipr_pkg::ATTR_MAX_INST: dat_d = cipr_pkg::ID_MAX_INST;
          cipr_pkg::ATTR_MAX_CLS: dat_d = cipr_pkg::ID_MAX_CLS_ATTR;
          cipr_pkg::ATTR_MAX_IATTR: dat_d = cipr_pkg::ID_MAX_INST_ATTR;
          default: err_d = 1'b1;
        endcase
      end else if (is_id && bus.service == cipr_pkg::SVC_GET_SGL) begin
        unique case (bus.attr)
          cipr_pkg::ATTR_VENDOR: dat_d = VENDOR_CODE;
          cipr_pkg::ATTR_PRODUCT: dat_d = PRODUCT_CODE;
          cipr_pkg::ATTR_STATUS: dat_d = bus.status_word;
          cipr_pkg::ATTR_STATE: dat_d = {8'h00, bus.state_byte};
          default: err_d = 1'b1;
        endcase
      end else if (is_id && bus.service == cipr_pkg::SVC_GET_ALL) begin
        dat_d = {cipr_pkg::ST_GETALL, cipr_pkg::ID_VERSION[7:0]};
      end else if (is_id && bus.service == cipr_pkg::SVC_RESET) begin
        rst_d = 1'b1;
      end else if (is_id) begin
        err_d = 1'b1;
      end else if (is_sub && bus.service == cipr_pkg::SVC_SET_SGL && bus.attr == cipr_pkg::ATTR_DATA) begin
        swe_d = 1'b1;
        sd_d = bus.wdata[3:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rv_q <= 1'b0;
      err_q <= 1'b0;
      dat_q <= '0;
      swe_q <= 1'b0;
      sd_q <= '0;
      rst_q <= 1'b0;
    end else begin
      rv_q <= rv_d;
      err_q <= err_d;
      dat_q <= dat_d;
      swe_q <= swe_d;
      sd_q <= sd_d;
      rst_q <= rst_d;
    end
  end

  assign bus.rsp_valid = rv_q;
  assign bus.rsp_err = err_q;
  assign bus.rsp_data = dat_q;
  assign bus.sub_we = swe_q;
  assign bus.sub_data = sd_q;
  assign bus.rst_svc = rst_q;

  property p_bad_no_effect;
    @(posedge sys_clk_i) disable iff (!resetn_i) err_q |-> !swe_q && !rst_q;
  endproperty
  a_bad_no_effect: assert property (p_bad_no_effect) else $error("error answer changed state");
  property p_bad_class;
    @(posedge sys_clk_i) disable iff (!resetn_i) bus.req_valid && !cls_ok(bus.class_code) |=> rv_q && err_q;
  endproperty
  a_bad_class: assert property (p_bad_class) else $error("bad class accepted");
endmodule
`default_nettype wire

// file: cipr_top.sv
// Top of the CIP I/O object responder
//
// Behaviour
// - Each input indicator is lit exactly while its digital input is active.
// - Each output indicator is yellow while the output is on, red when shorted or overloaded, else dark.
// - Indicator index is byte then bit, so bit n of process byte 0 maps to indicator n.
// - On a connection timeout the device forces its outputs to the safe state by itself.
// - Substitute output values written through assembly instance 102 are stored for the safe state.
// - Every explicit request gets exactly one response.
// - Output data arrive cyclically with each implicit frame at the scanner's packet interval.
// - Services 01, 02, 05, 09, 0E and 10 are recognised.
// - Classes 01, 04, 06, 08, 09, 47, 48, F5 and F6 are accepted.
// - Identity class reports version 1, max instance 1, max class attribute 7, max instance attribute 9.
// - Identity status word carries owned, configured, extended status and fault bits, bits 1 and 3 zero.
// - Identity state byte is 2 (standby), 3 (operational) or 4 (major recoverable fault), and a get-all reply carries 255.
// - The network indicator flashes red after an owner connection timeout.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`default_nettype none
module cipr_top #(
  parameter int FLASH_CYC = cipr_pkg::FLASH_CYC,
  parameter logic [15:0] VENDOR_CODE = 16'h00A5, // Arbitrary value
  parameter logic [15:0] PRODUCT_CODE = 16'h005A // Arbitrary value
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [cipr_pkg::AW-1:0] reg_addr_i,
  input wire logic [cipr_pkg::DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [cipr_pkg::DW-1:0] reg_rdata_o,
  input wire logic req_valid_i,
  input wire logic [7:0] req_service_i,
  input wire logic [7:0] req_class_i,
  input wire logic [7:0] req_instance_i,
  input wire logic [7:0] req_attr_i,
  input wire logic [15:0] req_wdata_i,
  output logic rsp_valid_o,
  output logic rsp_err_o,
  output logic [15:0] rsp_data_o,
  input wire logic io_frame_i,
  input wire logic [cipr_pkg::NUM_OUT-1:0] io_out_data_i,
  input wire logic [cipr_pkg::NUM_IN-1:0] din_i,
  input wire logic [cipr_pkg::NUM_OUT-1:0] short_i,
  output logic [cipr_pkg::NUM_OUT-1:0] dout_o,
  output logic [cipr_pkg::NUM_IN-1:0] led_in_o,
  output logic [cipr_pkg::NUM_OUT-1:0] led_out_yel_o,
  output logic [cipr_pkg::NUM_OUT-1:0] led_out_red_o,
  output logic net_red_o,
  output logic irq_o
);
  localparam int NI = cipr_pkg::NUM_IN;
  localparam int NO = cipr_pkg::NUM_OUT;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules
  cipr_req_if rq ();
  logic wd_owned, wd_timeout;
  logic [31:0] limit_q, limit_d;

  cipr_decode #(.VENDOR_CODE(VENDOR_CODE), .PRODUCT_CODE(PRODUCT_CODE)) u_dec (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .bus(rq)
  );

  cipr_wdog u_wd (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .kick_i(io_frame_i),
    .limit_i(limit_q),
    .owned_o(wd_owned),
    .timeout_o(wd_timeout)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [15:0] rpi_q, rpi_d;
  logic [2:0] mult_q, mult_d;
  logic [NO-1:0] sub_q, sub_d, ioout_q, ioout_d, dout_q, dout_d, short_q;
  logic cfg_q, cfg_d, tout_q, tout_d;
  localparam int IRQ_W_L = cipr_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] sts_q, sts_d, mask_q, mask_d, ev;
  logic [15:0] rdata_q, rdata_d, status_word;
  logic [7:0] state_byte;
  logic [31:0] fcnt_q, fcnt_d;
  logic flash_q, flash_d, net_q, net_d, irq_q, irq_d;
  logic [NI-1:0] ledi_q;
  logic [NO-1:0] ledy_q, ledr_q;
  logic rv_q, re_q;
  logic [15:0] rd_q;

  assign rq.req_valid = req_valid_i;
  assign rq.service = req_service_i;
  assign rq.class_code = req_class_i;
  assign rq.instance_id = req_instance_i;
  assign rq.attr = req_attr_i;
  assign rq.wdata = req_wdata_i;
  assign rq.status_word = status_word;
  assign rq.state_byte = state_byte;

  always_comb begin
    status_word = '0;
    status_word[cipr_pkg::SW_OWNED] = wd_owned;
    status_word[cipr_pkg::SW_CONFIGURED] = cfg_q;
    status_word[cipr_pkg::SW_EXT_TIMEOUT] = tout_q;
    status_word[cipr_pkg::SW_MINOR_REC] = |short_q;
    status_word[cipr_pkg::SW_MAJOR_REC] = tout_q;
    if (tout_q) begin
      state_byte = cipr_pkg::ST_MAJ_REC;
    end else if (wd_owned) begin
      state_byte = cipr_pkg::ST_OPER;
    end else begin
      state_byte = cipr_pkg::ST_STANDBY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and next state
  always_comb begin
    rpi_d = rpi_q;
    mult_d = mult_q;
    mask_d = mask_q;
    sub_d = sub_q;
    cfg_d = cfg_q;
    rdata_d = '0;
    limit_d = {16'h0000, rpi_q} << ({1'b0, mult_q} + cipr_pkg::MULT_BASE);
    ev = '0;
    ev[cipr_pkg::IRQ_TIMEOUT] = wd_timeout;
    ev[cipr_pkg::IRQ_SHORT] = |(short_i & ~short_q);
    ev[cipr_pkg::IRQ_BADREQ] = rq.rsp_valid && rq.rsp_err;
    sts_d = sts_q;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        cipr_pkg::REG_RPI: rpi_d = reg_wdata_i;
        cipr_pkg::REG_MULT: mult_d = reg_wdata_i[2:0];
        cipr_pkg::REG_IRQ_STS: sts_d = sts_q & ~reg_wdata_i[IRQ_W_L-1:0];
        cipr_pkg::REG_IRQ_MASK: mask_d = reg_wdata_i[IRQ_W_L-1:0];
        default: ;
      endcase
    end
    sts_d = sts_d | ev;
    if (rq.sub_we) begin
      sub_d = rq.sub_data;
      cfg_d = 1'b1;
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        cipr_pkg::REG_RPI: rdata_d = rpi_q;
        cipr_pkg::REG_MULT: rdata_d = {13'h0000, mult_q};
        cipr_pkg::REG_IRQ_STS: rdata_d = {13'h0000, sts_q};
        cipr_pkg::REG_IRQ_MASK: rdata_d = {13'h0000, mask_q};
        cipr_pkg::REG_ID_STATUS: rdata_d = status_word;
        cipr_pkg::REG_ID_STATE: rdata_d = {8'h00, state_byte};
        cipr_pkg::REG_SUBST: rdata_d = {12'h000, sub_q};
        default: rdata_d = '0;
      endcase
    end
    irq_d = |(sts_d & mask_d);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, timeout and indicators
  always_comb begin
    ioout_d = io_frame_i ? io_out_data_i : ioout_q;
    tout_d = tout_q;
    if (wd_timeout) begin
      tout_d = 1'b1;
    end else if (io_frame_i || rq.rst_svc) begin
      tout_d = 1'b0;
    end
    dout_d = tout_d ? sub_d : ioout_d;
    fcnt_d = fcnt_q + 32'h0000_0001;
    flash_d = flash_q;
    if (fcnt_q >= 32'(FLASH_CYC - 1)) begin
      fcnt_d = '0;
      flash_d = !flash_q;
    end
    net_d = tout_d && flash_d;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rpi_q <= cipr_pkg::RPI_RST;
      mult_q <= cipr_pkg::MULT_RST;
      limit_q <= '0;
      sts_q <= '0;
      mask_q <= '0;
      sub_q <= '0;
      cfg_q <= 1'b0;
      rdata_q <= '0;
      irq_q <= 1'b0;
      ioout_q <= '0;
      tout_q <= 1'b0;
      dout_q <= '0;
      fcnt_q <= '0;
      flash_q <= 1'b0;
      net_q <= 1'b0;
      short_q <= '0;
      ledi_q <= '0;
      ledy_q <= '0;
      ledr_q <= '0;
      rv_q <= 1'b0;
      re_q <= 1'b0;
      rd_q <= '0;
    end else begin
      rpi_q <= rpi_d;
      mult_q <= mult_d;
      limit_q <= limit_d;
      sts_q <= sts_d;
      mask_q <= mask_d;
      sub_q <= sub_d;
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      ioout_q <= ioout_d;
      tout_q <= tout_d;
      dout_q <= dout_d;
      fcnt_q <= fcnt_d;
      flash_q <= flash_d;
      net_q <= net_d;
      short_q <= short_i;
      ledi_q <= din_i;
      ledy_q <= dout_d & ~short_i;
      ledr_q <= short_i;
      rv_q <= rq.rsp_valid;
      re_q <= rq.rsp_err;
      rd_q <= rq.rsp_data;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign rsp_valid_o = rv_q;
  assign rsp_err_o = re_q;
  assign rsp_data_o = rd_q;
  assign dout_o = dout_q;
  assign led_in_o = ledi_q;
  assign led_out_yel_o = ledy_q;
  assign led_out_red_o = ledr_q;
  assign net_red_o = net_q;
  assign irq_o = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_one_rsp;
    @(posedge sys_clk_i) disable iff (!resetn_i) req_valid_i |-> ##2 rsp_valid_o;
  endproperty
  a_one_rsp: assert property (p_one_rsp) else $error("request without response");
  property p_no_spurious;
    @(posedge sys_clk_i) disable iff (!resetn_i) rsp_valid_o |-> $past(req_valid_i, 2);
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("response without request");
  property p_safe;
    @(posedge sys_clk_i) disable iff (!resetn_i) wd_timeout && !rq.sub_we |=> dout_o == sub_q && tout_q;
  endproperty
  a_safe: assert property (p_safe) else $error("outputs not safe after timeout");
  property p_led_in;
    @(posedge sys_clk_i) disable iff (!resetn_i) 1'b1 |=> led_in_o == $past(din_i);
  endproperty
  a_led_in: assert property (p_led_in) else $error("input indicator mismatch");
  property p_led_red;
    @(posedge sys_clk_i) disable iff (!resetn_i) ##1 (led_out_red_o & led_out_yel_o) == '0;
  endproperty
  a_led_red: assert property (p_led_red) else $error("output indicator both colours");
  property p_net;
    @(posedge sys_clk_i) disable iff (!resetn_i) net_red_o |-> tout_q;
  endproperty
  a_net: assert property (p_net) else $error("network red without timeout");
  property p_sw_rsvd;
    @(posedge sys_clk_i) disable iff (!resetn_i) !status_word[1] && !status_word[3];
  endproperty
  a_sw_rsvd: assert property (p_sw_rsvd) else $error("reserved status bits set");
  property p_state;
    @(posedge sys_clk_i) disable iff (!resetn_i) wd_owned && !tout_q |-> state_byte == cipr_pkg::ST_OPER;
  endproperty
  a_state: assert property (p_state) else $error("owned not operational");
  property p_limit;
    @(posedge sys_clk_i) disable iff (!resetn_i) reg_wr_i && reg_addr_i == cipr_pkg::REG_MULT
      |=> ##1 limit_q == ({16'h0000, rpi_q} << ({1'b0, mult_q} + cipr_pkg::MULT_BASE));
  endproperty
  a_limit: assert property (p_limit) else $error("timeout limit not derived");
  property p_sub;
    @(posedge sys_clk_i) disable iff (!resetn_i) rq.sub_we |=> sub_q == $past(rq.sub_data) && cfg_q;
  endproperty
  a_sub: assert property (p_sub) else $error("substitute not stored");
  c_timeout: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) wd_timeout);
  c_bad_req: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) rsp_valid_o && rsp_err_o);
  c_sub_wr: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) rq.sub_we);
  c_irq: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) irq_o);
endmodule
`default_nettype wire

// file: cipr_scan_model.sv
// Scanner model that sends cyclic implicit output frames
`default_nettype none
module cipr_scan_model (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic run_i,
  input wire logic [7:0] period_i,
  input wire logic [3:0] data_i,
  output logic frame_o,
  output logic [3:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_q;
  logic hit;
  assign hit = run_i && (cnt_q == 8'h00);
  // One frame every period_i cycles while running
  // Data line toggles between frames
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cnt_q <= 8'h00;
      frame_o <= 1'b0;
      data_o <= 4'h0;
    end else begin
      cnt_q <= (cnt_q >= period_i - 8'h01) ? 8'h00 : cnt_q + 8'h01;
      frame_o <= hit;
      data_o <= hit ? data_i : ~data_o;
    end
  end
endmodule
`default_nettype wire

// file: tb_cipr_io_object_responder.sv
// Testbench of the CIP I/O object responder
`default_nettype none
module tb_cipr_io_object_responder;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, wr, rd, rq, rv, re, frame, nred, irq, run;
  logic [3:0] addr, odat, sdat, shrt, dout, ly, lr;
  logic [15:0] wd, rdata, rwd, rdat;
  logic [7:0] svc, cls, ins, att, din, lin, per;
  int n_errors, n_tests, cyc, i;
  logic [7:0] svcs [6] = '{8'h01, 8'h02, 8'h05, 8'h09, 8'h0E, 8'h10};
  logic [7:0] clss [8] = '{8'h04, 8'h06, 8'h08, 8'h09, 8'h47, 8'h48, 8'hF5, 8'hF6};
  cipr_top #(.FLASH_CYC(4)) uut (.sys_clk_i(clk), .resetn_i(rstn), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .req_valid_i(rq), .req_service_i(svc),
    .req_class_i(cls), .req_instance_i(ins), .req_attr_i(att), .req_wdata_i(rwd), .rsp_valid_o(rv),
    .rsp_err_o(re), .rsp_data_o(rdat), .io_frame_i(frame), .io_out_data_i(odat), .din_i(din),
    .short_i(shrt), .dout_o(dout), .led_in_o(lin), .led_out_yel_o(ly), .led_out_red_o(lr),
    .net_red_o(nred), .irq_o(irq));
  cipr_scan_model scan (.sys_clk_i(clk), .resetn_i(rstn), .run_i(run), .period_i(per), .data_i(sdat),
    .frame_o(frame), .data_o(odat));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic req(input logic [7:0] s, c, n, t, input logic [15:0] d, input logic e, input logic [15:0] x);
    @(posedge clk);
    svc <= s;
    cls <= c;
    ins <= n;
    att <= t;
    rwd <= d;
    rq <= 1'b1;
    @(posedge clk);
    rq <= 1'b0;
    @(posedge clk);
    #1;
    chk({rv, re, 14'h0000}, {1'b1, e, 14'h0000});
    if (!e) chk(rdat, x);
  endtask
  task automatic waitfor(input logic [3:0] v);
    for (i = 0; i < 40 && dout !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk({12'h000, dout}, {12'h000, v});
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {rstn, wr, rd, rq, run, addr, wd, svc, cls, ins, att, rwd, sdat, shrt, din} = '0;
    per = 8'h04;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rreg(cipr_pkg::REG_RPI, 16'h2710);
    rreg(cipr_pkg::REG_MULT, 16'h0000);
    rreg(4'hF, 16'h0000);
    req(8'h0E, 8'h01, 8'h00, 8'h01, 16'h0000, 1'b0, 16'h0001);
    req(8'h0E, 8'h01, 8'h00, 8'h02, 16'h0000, 1'b0, 16'h0001);
    req(8'h0E, 8'h01, 8'h00, 8'h06, 16'h0000, 1'b0, 16'h0007);
    req(8'h0E, 8'h01, 8'h00, 8'h07, 16'h0000, 1'b0, 16'h0009);
    req(8'h01, 8'h01, 8'h01, 8'h00, 16'h0000, 1'b0, 16'hFF01);
    rreg(cipr_pkg::REG_ID_STATE, 16'h0002);
    req(8'h0E, 8'h01, 8'h01, 8'h08, 16'h0000, 1'b0, 16'h0002);
    req(8'h0E, 8'h01, 8'h01, 8'h01, 16'h0000, 1'b0, 16'h00A5);
    req(8'h09, 8'h01, 8'h01, 8'h00, 16'h0000, 1'b1, 16'h0000);
    req(8'h0E, 8'h01, 8'h00, 8'h03, 16'h0000, 1'b1, 16'h0000);
    for (int k = 0; k < 6; k++) req(svcs[k], 8'h04, 8'h01, 8'h04, 16'h0000, 1'b0, 16'h0000);
    for (int k = 0; k < 8; k++) req(8'h0E, clss[k], 8'h01, 8'h03, 16'h0000, 1'b0, 16'h0000);
    req(8'h03, 8'h04, 8'd102, 8'h03, 16'h0005, 1'b1, 16'h0000);
    req(8'h10, 8'h02, 8'd102, 8'h03, 16'h0005, 1'b1, 16'h0000);
    rreg(cipr_pkg::REG_SUBST, 16'h0000);
    rreg(cipr_pkg::REG_IRQ_STS, 16'h0004);
    wreg(cipr_pkg::REG_IRQ_STS, 16'h0004);
    req(8'h10, 8'h04, 8'd102, 8'h03, 16'h000A, 1'b0, 16'h0000);
    rreg(cipr_pkg::REG_SUBST, 16'h000A);
    req(8'h0E, 8'h01, 8'h01, 8'h05, 16'h0000, 1'b0, 16'h0004);
    rreg(cipr_pkg::REG_ID_STATUS, 16'h0004);
    rreg(cipr_pkg::REG_IRQ_STS, 16'h0000);
    wreg(cipr_pkg::REG_RPI, 16'h0002);
    wreg(cipr_pkg::REG_MULT, 16'hFFF9);
    rreg(cipr_pkg::REG_MULT, 16'h0001);
    sdat <= 4'h5;
    run <= 1'b1;
    repeat (30) @(posedge clk);
    #1;
    chk({12'h000, dout}, 16'h0005);
    rreg(cipr_pkg::REG_ID_STATUS, 16'h0005);
    rreg(cipr_pkg::REG_ID_STATE, 16'h0003);
    rreg(cipr_pkg::REG_IRQ_STS, 16'h0000);
    wreg(cipr_pkg::REG_IRQ_MASK, 16'h0001);
    run <= 1'b0;
    waitfor(4'hA);
    rreg(cipr_pkg::REG_IRQ_STS, 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    rreg(cipr_pkg::REG_ID_STATE, 16'h0004);
    for (i = 0; i < 12 && nred !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk({15'h0000, nred}, 16'h0001);
    wreg(cipr_pkg::REG_IRQ_STS, 16'h0001);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    req(8'h05, 8'h01, 8'h01, 8'h00, 16'h0000, 1'b0, 16'h0000);
    sdat <= 4'h3;
    run <= 1'b1;
    waitfor(4'h3);
    din <= 8'hA5;
    shrt <= 4'h1;
    repeat (3) @(posedge clk);
    #1;
    chk({8'h00, lin}, 16'h00A5);
    chk({8'h00, ly, lr}, 16'h0021);
    rreg(cipr_pkg::REG_IRQ_STS, 16'h0002);
    conclude();
  end
endmodule
`default_nettype wire
